// file: core/cltd_decoder.sv
// Decoder for control-flow, literal and table-access instruction words.
// Assumes words arrive from program memory synchronous to clk, the
// core's status flags are valid alongside each word, and an APB master.
//
// Operation
// - Conditional branches 1110 0ccc: one cycle, two when taken.
// - Changed program counter or true test costs a second, empty cycle.
// - Call is two words, 1110 110s then 1111 with twelve address bits.
// - Jump is two words, 1110 1111 then 1111 with twelve address bits.
// - A lone 1111 word executes as no-operation.
// - Word 0004 clears the watchdog, 0003 enters standby; one cycle.
// - Word 0005 pushes, 0006 pops the return stack; flags untouched.
// - Subroutine and interrupt returns take two cycles; latter sets enables.
// - Literal add and subtract: one cycle, all five arithmetic flags.
// - Literal and, or, xor: one cycle, zero and negative only.
// - Literal move and multiply: one cycle, no flags.
// - 0000 0001 0000 kkkk loads bank select low nibble, one cycle.
// - Pointer load: two words, two cycles, 12-bit literal, pointer ff.
// - Return with literal loads the working register, two cycles.
// - Words 0008 to 000B are two-cycle table reads with pointer modes.
// - Words 000C to 000F are table writes: two cycles, five if launching.
// - A launched memory write runs until it reports completion.
// - Port read-modify-write takes its operand from the pins.
// - Writing timer zero with d set clears an assigned prescaler.
`timescale 1ns/10ps
`include "cltd_defines.svh"

module cltd_decoder #(
  parameter int TBLW_EXTRA = `CLTD_TBLW_EXTRA
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] fetch_word,
  input  wire logic        fetch_valid,
  input  wire logic        flag_carry,
  input  wire logic        flag_zero,
  input  wire logic        flag_overflow,
  input  wire logic        flag_negative,
  input  wire logic        port_rmw,
  input  wire logic        timer_zero_write,
  input  wire logic        dest_applies,
  input  wire logic        dest_bit,
  input  wire logic        presc_assigned,
  input  wire logic        mem_write_done,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             fetch_ready,
  output cltd_pkg::cltd_op_e exec_op,
  output logic             exec_valid,
  output logic [7:0]       exec_literal,
  output logic [7:0]       branch_offset,
  output logic [19:0]      jump_target,
  output logic             fast_select,
  output logic [1:0]       ptr_select,
  output logic [11:0]      ptr_literal,
  output logic [1:0]       table_mode,
  output logic [4:0]       flag_update_mask,
  output logic             pc_change,
  output logic             watchdog_clear,
  output logic             standby_enter,
  output logic             irq_enable_set,
  output logic             mem_write_start,
  output logic             mem_write_busy,
  output logic             operand_from_pins,
  output logic             prescaler_clear,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ==========================================================
  // Helpers
  function automatic cltd_pkg::cltd_op_e decode_op(input logic [15:0] w);
    cltd_pkg::cltd_op_e r;
    r = cltd_pkg::OP_OTHER;
    if (w[15:12] == `CLTD_SECOND_NIB) r = cltd_pkg::OP_NOP;
    else if (w[15:11] == `CLTD_BRANCH_HI5) r = cltd_pkg::OP_BRANCH;
    else if (w[15:9] == `CLTD_CALL_HI7) r = cltd_pkg::OP_CALL;
    else if (w[15:8] == `CLTD_JUMP_HI) r = cltd_pkg::OP_JUMP;
    else if (w[15:6] == `CLTD_PTR_HI10) r = cltd_pkg::OP_PTR;
    else if (w[15:8] == `CLTD_ADD_HI) r = cltd_pkg::OP_ADD;
    else if (w[15:8] == `CLTD_SUB_HI) r = cltd_pkg::OP_SUB;
    else if (w[15:8] == `CLTD_AND_HI) r = cltd_pkg::OP_AND;
    else if (w[15:8] == `CLTD_OR_HI) r = cltd_pkg::OP_OR;
    else if (w[15:8] == `CLTD_XOR_HI) r = cltd_pkg::OP_XOR;
    else if (w[15:8] == `CLTD_MOVE_HI) r = cltd_pkg::OP_MOVE;
    else if (w[15:8] == `CLTD_MUL_HI) r = cltd_pkg::OP_MUL;
    else if (w[15:8] == `CLTD_RETLIT_HI) r = cltd_pkg::OP_RETLIT;
    else if (w[15:4] == `CLTD_BANK_HI12) r = cltd_pkg::OP_BANK;
    else if (w[15:1] == `CLTD_RETURN_HI15) r = cltd_pkg::OP_RETURN;
    else if (w[15:1] == `CLTD_IRET_HI15) r = cltd_pkg::OP_IRET;
    else if (w[15:2] == `CLTD_TABLE_READ_OP_HI14) r = cltd_pkg::OP_TABLE_READ_OP;
    else if (w[15:2] == `CLTD_TBLWR_HI14) r = cltd_pkg::OP_TBLWR;
    else if (w == `CLTD_WDT_WORD) r = cltd_pkg::OP_WDT;
    else if (w == `CLTD_STBY_WORD) r = cltd_pkg::OP_STBY;
    else if (w == `CLTD_PUSH_WORD) r = cltd_pkg::OP_PUSH;
    else if (w == `CLTD_POP_WORD) r = cltd_pkg::OP_POP;
    else if (w == `CLTD_NOP_WORD) r = cltd_pkg::OP_NOP;
    return r;
  endfunction

  function automatic logic [4:0] flag_mask_of(input cltd_pkg::cltd_op_e op);
    logic [4:0] m;
    m = `CLTD_MASK_NONE;
    if (op == cltd_pkg::OP_ADD || op == cltd_pkg::OP_SUB)
      m = `CLTD_MASK_ARITH;
    else if (op == cltd_pkg::OP_AND || op == cltd_pkg::OP_OR || op == cltd_pkg::OP_XOR)
      m = `CLTD_MASK_LOGIC;
    return m;
  endfunction

  // Code bits 2:1 pick zero, carry, overflow or negative; bit 0 inverts.
  function automatic logic branch_true(input logic [2:0] c, input logic [3:0] f);
    return f[c[2:1]] ^ c[0];
  endfunction

  localparam logic [2:0] EXTRA = 3'(TBLW_EXTRA);

  cltd_pkg::cltd_state_s st_reg;
  cltd_pkg::cltd_state_s st_next;
  cltd_pkg::cltd_op_e    dec_op;
  logic                  accept;
  logic                  cond_true;
  logic                  apb_access;

  assign dec_op     = decode_op(fetch_word);
  assign accept     = st_reg.state == cltd_pkg::ST_DECODE && fetch_valid &&
                      st_reg.fetch_ready && st_reg.ctrl[`CLTD_CTRL_EN_BIT];
  assign cond_true  = branch_true(fetch_word[10:8],
                      {flag_negative, flag_overflow, flag_carry, flag_zero});
  assign apb_access = psel && penable && !st_reg.pready;

  // ==========================================================
  // Next state
  always_comb begin
    st_next            = st_reg;
    st_next.exec_valid = 1'b0;
    st_next.taken      = 1'b0;
    st_next.wdt_clear  = 1'b0;
    st_next.standby    = 1'b0;
    st_next.irq_set    = 1'b0;
    st_next.mem_start  = 1'b0;
    st_next.pready     = 1'b0;
    st_next.pslverr    = 1'b0;
    st_next.pins_src   = port_rmw;
    st_next.presc_clr  = timer_zero_write && presc_assigned &&
                         (dest_bit || !dest_applies);
    if (mem_write_done) begin
      st_next.mem_busy = 1'b0;
    end
    case (st_reg.state)
      cltd_pkg::ST_DECODE: begin
        if (accept) begin
          st_next.op        = dec_op;
          st_next.literal   = fetch_word[7:0];
          st_next.flag_mask = flag_mask_of(dec_op);
          st_next.exec_valid = 1'b1;
          st_next.exec_count = st_reg.exec_count + 16'h0001;
          case (dec_op)
            cltd_pkg::OP_BRANCH: begin
              st_next.offset = fetch_word[7:0];
              if (cond_true) begin
                st_next.taken = 1'b1;
                st_next.state = cltd_pkg::ST_FLUSH;
              end
            end
            cltd_pkg::OP_CALL, cltd_pkg::OP_JUMP, cltd_pkg::OP_PTR: begin
              // Execution waits for the operand word.
              st_next.exec_valid = 1'b0;
              st_next.exec_count = st_reg.exec_count;
              st_next.first_hi   = fetch_word[15:8];
              st_next.first_lo   = fetch_word[7:0];
              st_next.state      = cltd_pkg::ST_OPERAND;
            end
            cltd_pkg::OP_WDT: st_next.wdt_clear = 1'b1;
            cltd_pkg::OP_STBY: st_next.standby = 1'b1;
            cltd_pkg::OP_BANK: st_next.literal = {4'h0, fetch_word[3:0]};
            cltd_pkg::OP_RETURN, cltd_pkg::OP_IRET, cltd_pkg::OP_RETLIT: begin
              st_next.fast    = fetch_word[0];
              st_next.taken   = 1'b1;
              st_next.irq_set = dec_op == cltd_pkg::OP_IRET;
              st_next.state   = cltd_pkg::ST_FLUSH;
            end
            cltd_pkg::OP_TABLE_READ_OP: begin
              st_next.tbl_mode = fetch_word[1:0];
              st_next.state    = cltd_pkg::ST_FLUSH;
            end
            cltd_pkg::OP_TBLWR: begin
              st_next.tbl_mode = fetch_word[1:0];
              st_next.state    = cltd_pkg::ST_FLUSH;
              if (st_reg.ctrl[`CLTD_CTRL_LNCH_BIT]) begin
                st_next.hold_cnt  = EXTRA;
                st_next.mem_start = 1'b1;
                st_next.mem_busy  = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      cltd_pkg::ST_OPERAND: begin
        if (fetch_valid) begin
          // The second word is consumed as an operand, never decoded.
          st_next.exec_valid = 1'b1;
          st_next.exec_count = st_reg.exec_count + 16'h0001;
          st_next.target     = {fetch_word[11:0], st_reg.first_lo};
          st_next.fast       = st_reg.first_hi[0];
          st_next.ptr_sel    = st_reg.first_lo[5:4];
          st_next.ptr_lit    = {st_reg.first_lo[3:0], fetch_word[7:0]};
          st_next.taken      = st_reg.op != cltd_pkg::OP_PTR;
          st_next.state      = cltd_pkg::ST_DECODE;
        end
      end
      cltd_pkg::ST_FLUSH: begin
        // The prefetched word is dropped; this cycle executes as empty.
        if (st_reg.hold_cnt != 3'h0) st_next.state = cltd_pkg::ST_TBLW;
        else st_next.state = cltd_pkg::ST_DECODE;
      end
      default: begin
        st_next.hold_cnt = st_reg.hold_cnt - 3'h1;
        if (st_reg.hold_cnt == 3'h1) st_next.state = cltd_pkg::ST_DECODE;
      end
    endcase
    st_next.fetch_ready = st_next.state != cltd_pkg::ST_TBLW;

    // APB slave: one wait state, error on unmapped offsets.
    if (apb_access) begin
      st_next.pready = 1'b1;
      if (paddr == `CLTD_CTRL_OFF) begin
        st_next.prdata = {30'h0, st_reg.ctrl};
      end else if (paddr == `CLTD_STATUS_OFF) begin
        st_next.prdata = {24'h0, st_reg.op, st_reg.mem_busy, st_reg.state};
      end else if (paddr == `CLTD_COUNT_OFF) begin
        st_next.prdata = {16'h0, st_reg.exec_count};
      end else begin
        st_next.prdata  = 32'h0;
        st_next.pslverr = 1'b1;
      end
    end
    // The write lands at the completing edge, so an abandoned access changes nothing.
    if (psel && penable && pwrite && st_reg.pready && paddr == `CLTD_CTRL_OFF) begin
      st_next.ctrl = pwdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg             <= '0;
      st_reg.ctrl        <= `CLTD_CTRL_RST;
      st_reg.fetch_ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign fetch_ready       = st_reg.fetch_ready;
  assign exec_op           = st_reg.op;
  assign exec_valid        = st_reg.exec_valid;
  assign exec_literal      = st_reg.literal;
  assign branch_offset     = st_reg.offset;
  assign jump_target       = st_reg.target;
  assign fast_select       = st_reg.fast;
  assign ptr_select        = st_reg.ptr_sel;
  assign ptr_literal       = st_reg.ptr_lit;
  assign table_mode        = st_reg.tbl_mode;
  assign flag_update_mask  = st_reg.flag_mask;
  assign pc_change         = st_reg.taken;
  assign watchdog_clear    = st_reg.wdt_clear;
  assign standby_enter     = st_reg.standby;
  assign irq_enable_set    = st_reg.irq_set;
  assign mem_write_start   = st_reg.mem_start;
  assign mem_write_busy    = st_reg.mem_busy;
  assign operand_from_pins = st_reg.pins_src;
  assign prescaler_clear   = st_reg.presc_clr;
  assign prdata            = st_reg.prdata;
  assign pready            = st_reg.pready;
  assign pslverr           = st_reg.pslverr;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence first_of_two_s;
    accept && (dec_op == cltd_pkg::OP_CALL || dec_op == cltd_pkg::OP_JUMP ||
               dec_op == cltd_pkg::OP_PTR);
  endsequence
  sequence launch_s;
    accept && dec_op == cltd_pkg::OP_TBLWR && st_reg.ctrl[`CLTD_CTRL_LNCH_BIT];
  endsequence
  sequence long_stall_s;
    st_reg.state == cltd_pkg::ST_FLUSH ##1 (!fetch_ready)[*3] ##1 fetch_ready;
  endsequence

  branch_taken_a: assert property (accept && dec_op == cltd_pkg::OP_BRANCH |=>
    pc_change == $past(cond_true) && (st_reg.state == cltd_pkg::ST_FLUSH) == $past(cond_true))
    else $error("branch timing does not follow its condition");
  return_cycles_a: assert property (exec_valid && pc_change && exec_op inside
    {cltd_pkg::OP_RETURN, cltd_pkg::OP_IRET, cltd_pkg::OP_RETLIT} |->
    st_reg.state == cltd_pkg::ST_FLUSH ##1 st_reg.state == cltd_pkg::ST_DECODE)
    else $error("return did not take two cycles");
  two_word_a: assert property (first_of_two_s |=> st_reg.state == cltd_pkg::ST_OPERAND &&
    !exec_valid && st_reg.first_lo == $past(fetch_word[7:0]))
    else $error("first word not held for its operand");
  lone_nop_a: assert property (accept && fetch_word[15:12] == `CLTD_SECOND_NIB |=>
    exec_valid && exec_op == cltd_pkg::OP_NOP && !pc_change)
    else $error("lone second word did not execute as empty");
  watchdog_pulse_a: assert property (accept && fetch_word == `CLTD_WDT_WORD |=>
    watchdog_clear && !standby_enter ##1 (!watchdog_clear || exec_valid && exec_op == cltd_pkg::OP_WDT))
    else $error("watchdog clear not a single pulse");
  logic_flags_a: assert property (exec_valid && exec_op inside
    {cltd_pkg::OP_AND, cltd_pkg::OP_OR, cltd_pkg::OP_XOR} |-> flag_update_mask == 5'h05)
    else $error("logic literal flag mask wrong");
  arith_flags_a: assert property (exec_valid && exec_op inside
    {cltd_pkg::OP_ADD, cltd_pkg::OP_SUB} |-> flag_update_mask == 5'h1F)
    else $error("arithmetic literal flag mask wrong");
  quiet_flags_a: assert property (exec_valid && exec_op inside
    {cltd_pkg::OP_PUSH, cltd_pkg::OP_POP, cltd_pkg::OP_MOVE, cltd_pkg::OP_MUL} |->
    flag_update_mask == 5'h00)
    else $error("flagless operation updates flags");
  bank_load_a: assert property (exec_valid && exec_op == cltd_pkg::OP_BANK |->
    exec_literal[7:4] == 4'h0)
    else $error("bank load literal wider than four bits");
  table_write_a: assert property (launch_s |=> mem_write_start ##0 long_stall_s)
    else $error("launching table write not five cycles");
  mem_busy_hold_a: assert property (mem_write_busy && !mem_write_done |=> mem_write_busy)
    else $error("memory write dropped before completion");
  presc_clear_a: assert property (timer_zero_write && presc_assigned && dest_bit |=>
    prescaler_clear)
    else $error("prescaler not cleared on timer zero write");
  pins_source_a: assert property (port_rmw |=> operand_from_pins)
    else $error("port operand not taken from pins");
  table_read_a: assert property (accept && dec_op == cltd_pkg::OP_TABLE_READ_OP |=>
    exec_valid && st_reg.state == cltd_pkg::ST_FLUSH ##1 st_reg.state == cltd_pkg::ST_DECODE)
    else $error("table read not two cycles");

endmodule

// file: core/cltd_defines.svh
// Constants of the control, literal and table instruction decoder.
// Assumes inclusion by the decoder package and the decoder module only.
`ifndef CLTD_DEFINES_SVH
`define CLTD_DEFINES_SVH

// ==========================================================
// Register offsets and reset values
`define CLTD_CTRL_OFF     8'h00
`define CLTD_STATUS_OFF   8'h04
`define CLTD_COUNT_OFF    8'h08
`define CLTD_CTRL_RST     2'h1
`define CLTD_CTRL_EN_BIT  0
`define CLTD_CTRL_LNCH_BIT 1

// ==========================================================
// Opcode patterns
`define CLTD_SECOND_NIB   4'hF
`define CLTD_BRANCH_HI5   5'h1C
`define CLTD_CALL_HI7     7'h76
`define CLTD_JUMP_HI      8'hEF
`define CLTD_PTR_HI10     10'h3B8
`define CLTD_ADD_HI       8'h0F
`define CLTD_SUB_HI       8'h08
`define CLTD_AND_HI       8'h0B
`define CLTD_OR_HI        8'h09
`define CLTD_XOR_HI       8'h0A
`define CLTD_MOVE_HI      8'h0E
`define CLTD_MUL_HI       8'h0D
`define CLTD_RETLIT_HI    8'h0C
`define CLTD_BANK_HI12    12'h010
`define CLTD_RETURN_HI15  15'h0009
`define CLTD_IRET_HI15    15'h0008
`define CLTD_TABLE_READ_OP_HI14   14'h0002
`define CLTD_TBLWR_HI14   14'h0003
`define CLTD_WDT_WORD     16'h0004
`define CLTD_STBY_WORD    16'h0003
`define CLTD_PUSH_WORD    16'h0005
`define CLTD_POP_WORD     16'h0006
`define CLTD_NOP_WORD     16'h0000

// ==========================================================
// Flag masks, order carry, digit carry, zero, overflow, negative
`define CLTD_MASK_ARITH   5'h1F
`define CLTD_MASK_LOGIC   5'h05
`define CLTD_MASK_NONE    5'h00

// ==========================================================
// Timing: extra stall cycles of a launching table write (5 - 2)
`define CLTD_TBLW_EXTRA   3

`endif

// file: core/cltd_pkg.sv
// Types of the control, literal and table instruction decoder.
// Assumes the defines header is compiled alongside.
`include "cltd_defines.svh"

package cltd_pkg;

  // ==========================================================
  // Sequencer states, Gray coded along decode-operand-flush-stall
  typedef enum logic [1:0] {
    ST_DECODE  = 2'h0,
    ST_OPERAND = 2'h1,
    ST_FLUSH   = 2'h3,
    ST_TBLW    = 2'h2
  } cltd_state_e;

  // ==========================================================
  // Decoded operation classes
  typedef enum logic [4:0] {
    OP_NOP, OP_BRANCH, OP_CALL, OP_JUMP, OP_WDT, OP_STBY, OP_PUSH,
    OP_POP, OP_RETURN, OP_IRET, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
    OP_MOVE, OP_MUL, OP_RETLIT, OP_BANK, OP_PTR, OP_TABLE_READ_OP, OP_TBLWR,
    OP_OTHER
  } cltd_op_e;

  typedef struct packed {
    cltd_state_e state;
    cltd_op_e    op;
    logic        exec_valid;
    logic [7:0]  first_hi;
    logic [7:0]  first_lo;
    logic [7:0]  literal;
    logic [7:0]  offset;
    logic [19:0] target;
    logic        fast;
    logic [1:0]  ptr_sel;
    logic [11:0] ptr_lit;
    logic [1:0]  tbl_mode;
    logic [4:0]  flag_mask;
    logic        taken;
    logic        wdt_clear;
    logic        standby;
    logic        irq_set;
    logic        fetch_ready;
    logic [2:0]  hold_cnt;
    logic        mem_start;
    logic        mem_busy;
    logic        pins_src;
    logic        presc_clr;
    logic [1:0]  ctrl;
    logic [15:0] exec_count;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cltd_state_s;

endpackage

// file: sim/cltd_prog_mem.sv
// Program memory model that offers instruction words with the core flags.
// Assumes the bench loads {flags, word} entries into q between clock edges.
`timescale 1ns/10ps

module cltd_prog_mem (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        fetch_ready,
  output logic      [15:0] fetch_word,
  output logic             fetch_valid,
  output logic      [3:0]  flags
);
  // ==========================================================
  // Word queue
  logic [19:0] q[$];

  initial begin
    fetch_word = 16'h0000;
    fetch_valid = 1'b0;
    flags = 4'h0;
  end

  // A word stays offered until taken; idle lines toggle so a stale word never looks fresh.
  always @(posedge clk) begin
    if (!rst && fetch_valid && fetch_ready) begin
      void'(q.pop_front());
    end
    if (q.size() > 0 && !(slow && fetch_valid && fetch_ready)) begin
      fetch_valid <= 1'b1;
      fetch_word <= q[0][15:0];
      flags <= q[0][19:16];
    end else begin
      fetch_valid <= 1'b0;
      fetch_word <= ~fetch_word;
      flags <= ~flags;
    end
  end
endmodule

// file: sim/tb_control_literal_table_decoder.sv
// Self-checking bench of the control, literal and table instruction decoder.
// Assumes the decoder, its package and the program memory model are compiled first.
`timescale 1ns/10ps

module tb_control_literal_table_decoder;
  // ==========================================================
  // Signals
  typedef struct packed {
    cltd_pkg::cltd_op_e op;
    logic [7:0]         lit;
    logic [4:0]         msk;
    logic               pcc;
    logic [3:0]         pul;
    logic [19:0]        aux;
  } cltd_note_s;
  localparam int STALL = 3;
  logic clk = 1'b0, rst = 1'b1, slow = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic port_rmw = 1'b0, timer_zero_write = 1'b0, dest_applies = 1'b0, dest_bit = 1'b0;
  logic presc_assigned = 1'b0, mem_write_done = 1'b0, fetch_valid, fetch_ready, exec_valid;
  logic fast_select, pc_change, watchdog_clear, standby_enter, irq_enable_set, mem_write_start;
  logic mem_write_busy, operand_from_pins, prescaler_clear, pready, pslverr;
  logic [7:0] paddr = 8'h00, exec_literal, branch_offset;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] fetch_word;
  logic [3:0] flags;
  logic [19:0] jump_target;
  logic [1:0] ptr_select, table_mode;
  logic [11:0] ptr_literal;
  logic [4:0] flag_update_mask;
  cltd_pkg::cltd_op_e exec_op;
  cltd_note_s expq[$];
  logic [1:0] rq[$];
  int err_total = 0, tests_run = 0, issued = 0;

  always #2.5 clk = ~clk;

  cltd_decoder #(.TBLW_EXTRA(STALL)) dut_u (
    .clk, .rst, .fetch_word, .fetch_valid, .flag_carry(flags[3]), .flag_zero(flags[2]),
    .flag_overflow(flags[1]), .flag_negative(flags[0]), .port_rmw, .timer_zero_write, .dest_applies,
    .dest_bit, .presc_assigned, .mem_write_done, .psel, .penable, .pwrite, .paddr, .pwdata, .fetch_ready,
    .exec_op, .exec_valid, .exec_literal, .branch_offset, .jump_target, .fast_select, .ptr_select,
    .ptr_literal, .table_mode, .flag_update_mask, .pc_change, .watchdog_clear, .standby_enter,
    .irq_enable_set, .mem_write_start, .mem_write_busy, .operand_from_pins, .prescaler_clear, .prdata,
    .pready, .pslverr
  );
  cltd_prog_mem mem_u (.clk, .rst, .slow, .fetch_ready, .fetch_word, .fetch_valid, .flags);

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Queues the words of one instruction, plus a filler for the dropped slot, and notes the result.
  task automatic ex(input int n, input logic [3:0] f, input logic [15:0] a, input logic [15:0] b,
                    input cltd_pkg::cltd_op_e op, input logic [7:0] lit, input logic [4:0] m,
                    input logic p, input logic [3:0] pu, input logic [19:0] x);
    mem_u.q.push_back({f, a});
    // A gapped memory offers nothing in the flush cycle, so no filler is dropped there.
    if (n > 1 && (!slow || op inside {cltd_pkg::OP_CALL, cltd_pkg::OP_JUMP, cltd_pkg::OP_PTR}))
      mem_u.q.push_back({4'h0, b});
    issued++;
    expq.push_back(cltd_note_s'{op, lit, m, p, pu, x});
  endtask

  task automatic drain;
    for (int i = 0; i < 500 && (expq.size() > 0 || mem_u.q.size() > 0); i++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("pending", 32'h0, expq.size());
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] ed,
                     input logic ee);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!w) chk("prdata", ed, prdata);
    chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================
  // Result watcher
  always @(posedge clk) begin
    cltd_note_s e;
    if (rst === 1'b0 && exec_valid === 1'b1) begin
      if (expq.size() == 0) chk("spare exec", 32'h0, 32'h1);
      else begin
        e = expq.pop_front();
        chk("op", e.op, exec_op);
        chk("mask", e.msk, flag_update_mask);
        chk("pc", e.pcc, pc_change);
        chk("pulses", e.pul, {watchdog_clear, standby_enter, irq_enable_set, mem_write_start});
        if (e.op inside {[cltd_pkg::OP_ADD:cltd_pkg::OP_BANK]}) chk("lit", e.lit, exec_literal);
        case (e.op)
          cltd_pkg::OP_BRANCH: chk("offset", e.aux, branch_offset);
          cltd_pkg::OP_CALL, cltd_pkg::OP_JUMP: chk("target", e.aux, jump_target);
          cltd_pkg::OP_PTR: chk("ptr", e.aux, {ptr_select, ptr_literal});
          cltd_pkg::OP_TABLE_READ_OP, cltd_pkg::OP_TBLWR: chk("mode", e.aux, table_mode);
          cltd_pkg::OP_RETURN, cltd_pkg::OP_IRET: chk("fast", e.aux, fast_select);
          default: ;
        endcase
      end
    end
  end

  // Random side inputs; their effect shows two edges after they are driven.
  always @(posedge clk) begin
    logic [4:0] r;
    logic [1:0] e2;
    r = 5'($urandom);
    {port_rmw, timer_zero_write, presc_assigned, dest_bit, dest_applies} <= r;
    if (rst !== 1'b0) rq.delete();
    else begin
      rq.push_back({r[4], r[3] & r[2] & (r[1] | !r[0])});
      if (rq.size() > 2) begin
        e2 = rq.pop_front();
        chk("pins", e2[1], operand_from_pins);
        chk("presc", e2[0], prescaler_clear);
      end
    end
  end

  initial begin
    #200000;
    err_total++;
    close_out;
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] l8;
    logic [3:0] f, zcvn;
    logic tk;
    int lows;
    logic [7:0] lhi[7] = '{8'h0F, 8'h08, 8'h0B, 8'h09, 8'h0A, 8'h0E, 8'h0D};
    logic [4:0] lmk[7] = '{5'h1F, 5'h1F, 5'h05, 5'h05, 5'h05, 5'h00, 5'h00};
    cltd_pkg::cltd_op_e lop[7] = '{cltd_pkg::OP_ADD, cltd_pkg::OP_SUB, cltd_pkg::OP_AND, cltd_pkg::OP_OR,
                                   cltd_pkg::OP_XOR, cltd_pkg::OP_MOVE, cltd_pkg::OP_MUL};
    void'($urandom(32'h8186));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0, 32'h1, 1'b0);
    apb(1'b1, 8'h0C, 32'h5, 32'h0, 1'b1);
    apb(1'b0, 8'h0C, 32'h0, 32'h0, 1'b1);
    ex(1, 0, 16'hF123, 0, cltd_pkg::OP_NOP, 0, 0, 0, 0, 0);
    ex(1, 0, 16'h0004, 0, cltd_pkg::OP_WDT, 0, 0, 0, 4'h8, 0);
    ex(1, 0, 16'h0003, 0, cltd_pkg::OP_STBY, 0, 0, 0, 4'h4, 0);
    ex(1, 0, 16'h0005, 0, cltd_pkg::OP_PUSH, 0, 0, 0, 0, 0);
    ex(1, 0, 16'h0006, 0, cltd_pkg::OP_POP, 0, 0, 0, 0, 0);
    ex(2, 0, 16'h0013, 16'hF000, cltd_pkg::OP_RETURN, 0, 0, 1, 0, 1);
    ex(2, 0, 16'h0010, 16'hF000, cltd_pkg::OP_IRET, 0, 0, 1, 4'h2, 0);
    ex(1, 0, 16'h010A, 0, cltd_pkg::OP_BANK, 8'h0A, 0, 0, 0, 0);
    ex(2, 0, 16'h0C5A, 16'hF000, cltd_pkg::OP_RETLIT, 8'h5A, 0, 1, 0, 0);
    ex(2, 0, 16'hED12, 16'hF345, cltd_pkg::OP_CALL, 0, 0, 1, 0, 20'h34512);
    ex(2, 0, 16'hEF78, 16'hF9AB, cltd_pkg::OP_JUMP, 0, 0, 1, 0, 20'h9AB78);
    ex(2, 0, 16'hEE2A, 16'hF0BC, cltd_pkg::OP_PTR, 0, 0, 0, 0, 20'h2ABC);
    for (int i = 0; i < 7; i++) begin
      l8 = 8'($urandom);
      ex(1, 0, {lhi[i], l8}, 0, lop[i], l8, lmk[i], 0, 0, 0);
    end
    drain;
    slow <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 24; i++) begin
      f = 4'($urandom);
      l8 = 8'($urandom);
      zcvn = {f[0], f[1], f[3], f[2]};
      tk = zcvn[i[2:1]] ^ i[0];
      ex(tk ? 2 : 1, f, {5'h1C, i[2:0], l8}, 16'hF000, cltd_pkg::OP_BRANCH, 0, 0, tk, 0, l8);
    end
    for (int i = 0; i < 8; i++) begin
      ex(2, 0, 16'(8 + i), 16'hF000, i < 4 ? cltd_pkg::OP_TABLE_READ_OP : cltd_pkg::OP_TBLWR, 0, 0, 0, 0, 20'(i % 4));
    end
    drain;
    slow <= 1'b0;
    apb(1'b1, 8'h00, 32'h3, 32'h0, 1'b0);
    apb(1'b0, 8'h00, 32'h0, 32'h3, 1'b0);
    ex(2, 0, 16'h000D, 16'hF000, cltd_pkg::OP_TBLWR, 0, 0, 0, 4'h1, 1);
    lows = 0;
    repeat (12) @(posedge clk) lows += (fetch_ready === 1'b0);
    chk("stall", STALL, lows);
    ex(1, 0, 16'h0F01, 0, cltd_pkg::OP_ADD, 8'h01, 5'h1F, 0, 0, 0);
    drain;
    chk("busy", 1, mem_write_busy);
    mem_write_done <= 1'b1;
    @(posedge clk);
    mem_write_done <= 1'b0;
    repeat (2) @(posedge clk);
    chk("busy", 0, mem_write_busy);
    apb(1'b0, 8'h08, 32'h0, 32'(issued), 1'b0);
    close_out;
  end
endmodule
